// [testbench/snsd_partner.sv]
`timescale 1ns/1ns
`default_nettype none

module snsd_partner (
    // Clock
    input wire logic clk,
    // Switch bank, bit 0 is switch one, on reads as one
    output var logic [7:0] cfgSwitch,
    // Programmable inputs
    output var logic progInputFour,
    output var logic progInputSix,
    // Encoder channels, bit 0 A, bit 1 B, bit 2 index
    output var logic [2:0] enc
);
    // Boot setting: address 5, code 2
    initial begin
        cfgSwitch = 8'h85;
        progInputFour = 1'b0;
        progInputSix = 1'b0;
        enc = 3'h0;
    end

    // Levels change just after a rising edge only
    task automatic set_sw(input logic [7:0] v);
        @(posedge clk);
        cfgSwitch <= v;
    endtask : set_sw

    task automatic set_in(input logic four, input logic six);
        @(posedge clk);
        progInputFour <= four;
        progInputSix <= six;
    endtask : set_in

    task automatic set_enc(input logic [2:0] v);
        @(posedge clk);
        enc <= v;
    endtask : set_enc
endmodule : snsd_partner

`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic clk = 1'b0, sysRst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatI = 32'h0, wbDatO, rd;
    logic wbAck, progInputFour, progInputSix, linkEnable, stepPulse, dirLevel;
    logic genInputFour, genInputSix, aP, aN, bP, bN, iP, iN;
    logic [7:0] cfgSwitch;
    logic [2:0] enc;
    logic [5:0] nodeAddr, expAddr;
    logic [1:0] rateCode, expRate;
    logic [11:0] baudDiv, p2pDiv, expDiv;
    logic [7:0] swTab [4] = '{8'h6A, 8'hBF, 8'hC1, 8'h00};
    int error_cnt = 0, n_tests = 0, pulses;

    always #25 clk = ~clk;

    snsd_partner snsd_partner_i (.clk(clk), .cfgSwitch(cfgSwitch),
        .progInputFour(progInputFour), .progInputSix(progInputSix), .enc(enc));

    snsd_setting_decoder snsd_setting_decoder_i (.clk(clk), .sys_rst(sysRst),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .cfgSwitch(cfgSwitch), .progInputFour(progInputFour), .progInputSix(progInputSix),
        .encChanA(enc[0]), .encChanB(enc[1]), .encIndex(enc[2]), .nodeAddr(nodeAddr),
        .rateCode(rateCode), .baudDiv(baudDiv), .linkEnable(linkEnable), .p2pDiv(p2pDiv),
        .stepPulse(stepPulse), .dirLevel(dirLevel), .genInputFour(genInputFour),
        .genInputSix(genInputSix), .bufferedChanAOutP(aP), .bufferedChanAOutN(aN),
        .bufferedChanBOutP(bP), .bufferedChanBOutN(bN), .bufferedIndexOutP(iP),
        .bufferedIndexOutN(iN));

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Classic cycle: hold everything until ack is sampled high
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                            input logic [31:0] dat, output logic [31:0] q);
        int n;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= sel;
        wbDatI <= dat;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (wbAck === 1'b1) break;
        end
        // Lost ack ends the run, the request is never dropped unanswered
        if (n == 50) begin
            chk(1'b0, 1'b1, "bus ack");
            stop_test();
        end
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask : wb_cycle

    // Settle plus resolve is about 201 cycles; allow twice that
    task automatic wait_link();
        int n;
        repeat (3) @(posedge clk);
        for (n = 0; n < 400; n++) begin
            @(posedge clk);
            if (linkEnable === 1'b1) break;
        end
        chk(linkEnable, 1'b1, "link enable");
    endtask : wait_link

    initial begin
        #(50 * 20000);
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        repeat (20) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        chk(nodeAddr, 6'h00, "reset address");
        chk(linkEnable, 1'b0, "reset link");
        chk(baudDiv, snsd_pkg::DIV_LO, "reset divisor");
        chk(aN, 1'b1, "reset inverse leg");
        chk(p2pDiv, snsd_pkg::P2P_DIV_RST, "reset point-to-point divisor");
        wb_cycle(1'b0, snsd_pkg::ADR_NVM_ADDR, 4'hF, 32'h0, rd);
        chk(rd, 32'h1, "memory address reset");
        wb_cycle(1'b1, snsd_pkg::ADR_NVM_ADDR, 4'h0, 32'h2A, rd);
        wb_cycle(1'b0, snsd_pkg::ADR_NVM_ADDR, 4'hF, 32'h0, rd);
        chk(rd, 32'h1, "memory address lane off");
        wb_cycle(1'b0, 8'h20, 4'hF, 32'h0, rd);
        chk(rd, 32'h0, "unmapped read");
        wait_link();
        chk(nodeAddr, 6'h05, "boot address");
        chk(baudDiv, snsd_pkg::DIV_MID, "boot divisor");
        // Memory fallbacks and a point-to-point setting the switches must not touch
        wb_cycle(1'b1, snsd_pkg::ADR_NVM_ADDR, 4'h1, 32'h15, rd);
        wb_cycle(1'b1, snsd_pkg::ADR_NVM_RATE, 4'h1, 32'h3, rd);
        wb_cycle(1'b1, snsd_pkg::ADR_P2P_DIV, 4'h3, 32'h123, rd);
        for (int k = 0; k < 4; k++) begin
            snsd_partner_i.set_sw(swTab[k]);
            wb_cycle(1'b1, snsd_pkg::ADR_CTRL, 4'h1, 32'h4, rd);
            wait_link();
            expAddr = (swTab[k][5:0] == 6'h00) ? 6'h15 : swTab[k][5:0];
            expRate = (swTab[k][7:6] == 2'h0) ? 2'h3 : swTab[k][7:6];
            expDiv = (expRate == 2'h1) ? snsd_pkg::DIV_LO :
                     (expRate == 2'h2) ? snsd_pkg::DIV_MID : snsd_pkg::DIV_HI;
            chk(nodeAddr, expAddr, "node address");
            chk(rateCode, expRate, "rate code");
            chk(baudDiv, expDiv, "divisor");
            chk(p2pDiv, 12'h123, "point-to-point divisor");
            wb_cycle(1'b0, snsd_pkg::ADR_STATUS, 4'hF, 32'h0, rd);
            chk(rd[23:0], {swTab[k], 6'h01, swTab[k][7:6] == 2'h0, swTab[k][5:0] == 6'h00,
                expRate, expAddr}, "status");
            wb_cycle(1'b0, snsd_pkg::ADR_BAUD_DIV, 4'hF, 32'h0, rd);
            chk(rd, {20'h0, expDiv}, "divisor register");
            // Later switch moves are ignored while running
            snsd_partner_i.set_sw(~swTab[k]);
            repeat (10) @(posedge clk);
            chk(nodeAddr, expAddr, "address held");
        end
        // Both rate sources blank fall back to the slowest rate
        wb_cycle(1'b1, snsd_pkg::ADR_NVM_RATE, 4'h1, 32'h0, rd);
        snsd_partner_i.set_sw(8'h00);
        wb_cycle(1'b1, snsd_pkg::ADR_CTRL, 4'h1, 32'h4, rd);
        wait_link();
        chk(nodeAddr, 6'h15, "blank switch address");
        chk(rateCode, snsd_pkg::RATE_LO, "blank rate code");
        chk(baudDiv, snsd_pkg::DIV_LO, "blank rate divisor");
        // Step and direction roles, then general roles
        wb_cycle(1'b1, snsd_pkg::ADR_CTRL, 4'h1, 32'h3, rd);
        snsd_partner_i.set_in(1'b1, 1'b1);
        pulses = 0;
        repeat (8) begin
            @(posedge clk);
            if (stepPulse === 1'b1) pulses++;
        end
        chk(pulses, 1, "step pulse count");
        chk({dirLevel, genInputFour, genInputSix}, 3'b100, "step role levels");
        wb_cycle(1'b1, snsd_pkg::ADR_CTRL, 4'h1, 32'h0, rd);
        repeat (3) @(posedge clk);
        chk({dirLevel, genInputFour, genInputSix}, 3'b011, "general role levels");
        for (int e = 0; e < 8; e++) begin
            snsd_partner_i.set_enc(e[2:0]);
            repeat (5) @(posedge clk);
            chk({iP, bP, aP, iN, bN, aN}, {e[2:0], ~e[2:0]}, "encoder copy");
        end
        stop_test();
    end
endmodule : tb

`default_nettype wire

// [verilog/snsd_pkg.sv]
package snsd_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned SETTLE_US = 10;
    localparam int unsigned SETTLE_CYC = (CLK_HZ / 1_000_000) * SETTLE_US;
    localparam int unsigned SETTLE_CNT_W = 8;
    localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_CNT_W'(SETTLE_CYC - 1);

    // Multi-drop bit rates in bits per second
    localparam int unsigned RATE_LO_BPS = 9_600;
    localparam int unsigned RATE_MID_BPS = 38_400;
    localparam int unsigned RATE_HI_BPS = 115_200;

    // Clock cycles per bit, rounded down
    localparam int unsigned DIV_W = 12;
    localparam logic [DIV_W-1:0] DIV_LO = DIV_W'(CLK_HZ / RATE_LO_BPS);
    localparam logic [DIV_W-1:0] DIV_MID = DIV_W'(CLK_HZ / RATE_MID_BPS);
    localparam logic [DIV_W-1:0] DIV_HI = DIV_W'(CLK_HZ / RATE_HI_BPS);

    // Bit-rate selection codes
    localparam logic [1:0] RATE_NVM = 2'h0;
    localparam logic [1:0] RATE_LO = 2'h1;
    localparam logic [1:0] RATE_MID = 2'h2;
    localparam logic [1:0] RATE_HI = 2'h3;

    // Switch field layout
    localparam int unsigned SW_ADDR_LSB = 0;
    localparam int unsigned SW_ADDR_W = 6;
    localparam int unsigned SW_RATE_LSB = 6;
    localparam int unsigned SW_RATE_W = 2;
    localparam logic [SW_ADDR_W-1:0] ADDR_ZERO = 6'h00;

    // Register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_NVM_ADDR = 8'h04;
    localparam logic [7:0] ADR_NVM_RATE = 8'h08;
    localparam logic [7:0] ADR_P2P_DIV = 8'h0C;
    localparam logic [7:0] ADR_STATUS = 8'h10;
    localparam logic [7:0] ADR_BAUD_DIV = 8'h14;

    // Control fields
    localparam int unsigned CTRL_STEP_BIT = 0;
    localparam int unsigned CTRL_DIR_BIT = 1;
    localparam int unsigned CTRL_RELOAD_BIT = 2;

    // Status fields
    localparam int unsigned ST_ADDR_LSB = 0;
    localparam int unsigned ST_RATE_LSB = 6;
    localparam int unsigned ST_ADDR_NVM_BIT = 8;
    localparam int unsigned ST_RATE_NVM_BIT = 9;
    localparam int unsigned ST_LINK_BIT = 10;
    localparam int unsigned ST_GEN4_BIT = 11;
    localparam int unsigned ST_GEN6_BIT = 12;
    localparam int unsigned ST_DIR_BIT = 13;
    localparam int unsigned ST_SW_LSB = 16;

    // Reset values
    localparam logic [SW_ADDR_W-1:0] NVM_ADDR_RST = 6'h01;
    localparam logic [1:0] NVM_RATE_RST = 2'h1;
    localparam logic [DIV_W-1:0] P2P_DIV_RST = DIV_LO;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_RESOLVE = 2'b01,
        ST_RUN = 2'b10
    } snsd_state_e;

endpackage : snsd_pkg

// [verilog/snsd_setting_decoder.sv]
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none

module snsd_setting_decoder (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Configuration switches, bit 0 is switch one
    input wire logic [7:0] cfgSwitch,
    // Programmable inputs
    input wire logic progInputFour,
    input wire logic progInputSix,
    // Motor encoder inputs
    input wire logic encChanA,
    input wire logic encChanB,
    input wire logic encIndex,
    // Resolved multi-drop settings
    output logic [5:0] nodeAddr,
    output logic [1:0] rateCode,
    output logic [11:0] baudDiv,
    output logic linkEnable,
    // Point-to-point port setting
    output logic [11:0] p2pDiv,
    // Step, direction and general inputs
    output logic stepPulse,
    output logic dirLevel,
    output logic genInputFour,
    output logic genInputSix,
    // Buffered encoder pairs
    output logic bufferedChanAOutP,
    output logic bufferedChanAOutN,
    output logic bufferedChanBOutP,
    output logic bufferedChanBOutN,
    output logic bufferedIndexOutP,
    output logic bufferedIndexOutN
);

    logic [7:0] swSync, latchedSw_q;
    logic [4:0] pinSync;
    logic busReq, wrStb, rdStb, ack_q;
    logic [31:0] rdData_q, rdMux;
    logic ctrlStep_q, ctrlDir_q, reloadReq_q;
    logic [5:0] nvmAddr_q, nodeAddr_q, swAddr;
    logic [1:0] nvmRate_q, rateCode_q, swRate, effRate;
    logic [11:0] p2pDiv_q, baudDiv_q;
    snsd_pkg::snsd_state_e state_q;
    logic [snsd_pkg::SETTLE_CNT_W-1:0] settleCnt_q;
    logic addrFromNvm_q, rateFromNvm_q;
    logic in4Prev_q, stepPulse_q, dirLevel_q, genIn4_q, genIn6_q;
    logic [2:0] encBufP_q, encBufN_q;

    function automatic logic [11:0] divFor(input logic [1:0] code);
        logic [11:0] d;
        d = snsd_pkg::DIV_LO;
        case (code)
            snsd_pkg::RATE_MID: d = snsd_pkg::DIV_MID;
            snsd_pkg::RATE_HI: d = snsd_pkg::DIV_HI;
            default: d = snsd_pkg::DIV_LO;
        endcase
        return d;
    endfunction : divFor

    // Pins are asynchronous to clk
    snsd_sync #(.WIDTH(8)) uSwitchSync (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn(cfgSwitch),
        .syncOut(swSync)
    );

    snsd_sync #(.WIDTH(5)) uPinSync (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn({encIndex, encChanB, encChanA, progInputSix, progInputFour}),
        .syncOut(pinSync)
    );

    // Bus slave: one wait cycle, unmapped reads return zero
    assign busReq = wb_cyc_i & wb_stb_i;
    assign wrStb = busReq & wb_we_i & ~ack_q;
    assign rdStb = busReq & ~wb_we_i & ~ack_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdData_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= busReq & ~ack_q;
        end
    end

    always_comb begin
        rdMux = 32'h0000_0000;
        case (wb_adr_i)
            snsd_pkg::ADR_CTRL: begin
                rdMux[snsd_pkg::CTRL_STEP_BIT] = ctrlStep_q;
                rdMux[snsd_pkg::CTRL_DIR_BIT] = ctrlDir_q;
            end
            snsd_pkg::ADR_NVM_ADDR: rdMux[5:0] = nvmAddr_q;
            snsd_pkg::ADR_NVM_RATE: rdMux[1:0] = nvmRate_q;
            snsd_pkg::ADR_P2P_DIV: rdMux[11:0] = p2pDiv_q;
            snsd_pkg::ADR_STATUS: begin
                rdMux[snsd_pkg::ST_ADDR_LSB +: 6] = nodeAddr_q;
                rdMux[snsd_pkg::ST_RATE_LSB +: 2] = rateCode_q;
                rdMux[snsd_pkg::ST_ADDR_NVM_BIT] = addrFromNvm_q;
                rdMux[snsd_pkg::ST_RATE_NVM_BIT] = rateFromNvm_q;
                rdMux[snsd_pkg::ST_LINK_BIT] = linkEnable;
                rdMux[snsd_pkg::ST_GEN4_BIT] = genIn4_q;
                rdMux[snsd_pkg::ST_GEN6_BIT] = genIn6_q;
                rdMux[snsd_pkg::ST_DIR_BIT] = dirLevel_q;
                rdMux[snsd_pkg::ST_SW_LSB +: 8] = latchedSw_q;
            end
            snsd_pkg::ADR_BAUD_DIV: rdMux[11:0] = baudDiv_q;
            default: rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_q <= 32'h0000_0000;
        end else if (rdStb) begin
            rdData_q <= rdMux;
        end
    end

    // Software registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlStep_q <= 1'b0;
            ctrlDir_q <= 1'b0;
            reloadReq_q <= 1'b0;
            nvmAddr_q <= snsd_pkg::NVM_ADDR_RST;
            nvmRate_q <= snsd_pkg::NVM_RATE_RST;
        end else begin
            reloadReq_q <= 1'b0;
            if (wrStb && wb_sel_i[0]) begin
                case (wb_adr_i)
                    snsd_pkg::ADR_CTRL: begin
                        ctrlStep_q <= wb_dat_i[snsd_pkg::CTRL_STEP_BIT];
                        ctrlDir_q <= wb_dat_i[snsd_pkg::CTRL_DIR_BIT];
                        reloadReq_q <= wb_dat_i[snsd_pkg::CTRL_RELOAD_BIT];
                    end
                    snsd_pkg::ADR_NVM_ADDR: nvmAddr_q <= wb_dat_i[5:0];
                    snsd_pkg::ADR_NVM_RATE: nvmRate_q <= wb_dat_i[1:0];
                    default: ;
                endcase
            end
        end
    end

    // Written only by software, no switch term
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            p2pDiv_q <= snsd_pkg::P2P_DIV_RST;
        end else if (wrStb && wb_adr_i == snsd_pkg::ADR_P2P_DIV) begin
            if (wb_sel_i[0]) begin
                p2pDiv_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                p2pDiv_q[11:8] <= wb_dat_i[11:8];
            end
        end
    end

    // Sequencer: settle, resolve once, run
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= snsd_pkg::ST_SETTLE;
            settleCnt_q <= '0;
        end else begin
            case (state_q)
                snsd_pkg::ST_SETTLE: begin
                    if (settleCnt_q == snsd_pkg::SETTLE_LAST) begin
                        settleCnt_q <= '0;
                        state_q <= snsd_pkg::ST_RESOLVE;
                    end else begin
                        settleCnt_q <= settleCnt_q + 1'b1;
                    end
                end
                snsd_pkg::ST_RESOLVE: state_q <= snsd_pkg::ST_RUN;
                snsd_pkg::ST_RUN: begin
                    if (reloadReq_q) begin
                        state_q <= snsd_pkg::ST_SETTLE;
                    end
                end
                default: state_q <= snsd_pkg::ST_SETTLE;
            endcase
        end
    end

    assign swAddr = swSync[snsd_pkg::SW_ADDR_LSB +: snsd_pkg::SW_ADDR_W];
    assign swRate = swSync[snsd_pkg::SW_RATE_LSB +: snsd_pkg::SW_RATE_W];

    // A blank memory code falls back to the slowest rate
    assign effRate = (swRate != snsd_pkg::RATE_NVM) ? swRate :
                     (nvmRate_q != snsd_pkg::RATE_NVM) ? nvmRate_q : snsd_pkg::RATE_LO;

    // Settings only move in the resolve cycle, so the link sees them stable
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            latchedSw_q <= 8'h00;
            nodeAddr_q <= 6'h00;
            rateCode_q <= 2'h0;
            baudDiv_q <= snsd_pkg::DIV_LO;
            addrFromNvm_q <= 1'b0;
            rateFromNvm_q <= 1'b0;
        end else if (state_q == snsd_pkg::ST_RESOLVE) begin
            latchedSw_q <= swSync;
            if (swAddr == snsd_pkg::ADDR_ZERO) begin
                nodeAddr_q <= nvmAddr_q;
                addrFromNvm_q <= 1'b1;
            end else begin
                nodeAddr_q <= swAddr;
                addrFromNvm_q <= 1'b0;
            end
            rateCode_q <= effRate;
            rateFromNvm_q <= (swRate == snsd_pkg::RATE_NVM);
            baudDiv_q <= divFor(effRate);
        end
    end

    assign nodeAddr = nodeAddr_q;
    assign rateCode = rateCode_q;
    assign baudDiv = baudDiv_q;
    assign linkEnable = (state_q == snsd_pkg::ST_RUN);
    assign p2pDiv = p2pDiv_q;

    // Step and direction roles
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            in4Prev_q <= 1'b0;
            stepPulse_q <= 1'b0;
            dirLevel_q <= 1'b0;
            genIn4_q <= 1'b0;
            genIn6_q <= 1'b0;
        end else begin
            in4Prev_q <= pinSync[0];
            stepPulse_q <= ctrlStep_q & pinSync[0] & ~in4Prev_q;
            dirLevel_q <= ctrlDir_q & pinSync[1];
            genIn4_q <= ~ctrlStep_q & pinSync[0];
            genIn6_q <= ~ctrlDir_q & pinSync[1];
        end
    end

    assign stepPulse = stepPulse_q;
    assign dirLevel = dirLevel_q;
    assign genInputFour = genIn4_q;
    assign genInputSix = genIn6_q;

    // Both legs registered to keep the pair skew-free
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            encBufP_q <= 3'h0;
            encBufN_q <= 3'h7;
        end else begin
            encBufP_q <= pinSync[4:2];
            encBufN_q <= ~pinSync[4:2];
        end
    end

    assign bufferedChanAOutP = encBufP_q[0];
    assign bufferedChanAOutN = encBufN_q[0];
    assign bufferedChanBOutP = encBufP_q[1];
    assign bufferedChanBOutN = encBufN_q[1];
    assign bufferedIndexOutP = encBufP_q[2];
    assign bufferedIndexOutN = encBufN_q[2];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    switchAddr_a: assert property (
        state_q == snsd_pkg::ST_RESOLVE && swAddr != 6'h00 |=> nodeAddr_q == $past(swAddr)
    ) else $error("node address not taken from switches");
    switchRate_a: assert property (
        state_q == snsd_pkg::ST_RESOLVE && swRate != 2'h0 |=> rateCode_q == $past(swRate)
    ) else $error("rate code not taken from switches");
    nvmAddr_a: assert property (
        state_q == snsd_pkg::ST_RESOLVE && swAddr == 6'h00
        |=> nodeAddr_q == $past(nvmAddr_q) && addrFromNvm_q
    ) else $error("zero address did not fall back to memory");
    nvmRate_a: assert property (
        state_q == snsd_pkg::ST_RESOLVE && swRate == 2'h0 && nvmRate_q != 2'h0
        |=> rateCode_q == $past(nvmRate_q) && rateFromNvm_q
    ) else $error("zero rate did not fall back to memory");
    rateDivisor_a: assert property (
        linkEnable |-> (rateCode_q == 2'h1 && baudDiv_q == 12'h823)
            || (rateCode_q == 2'h2 && baudDiv_q == 12'h208)
            || (rateCode_q == 2'h3 && baudDiv_q == 12'h0AD)
    ) else $error("bit rate divisor does not match code");
    p2pIsolated_a: assert property (
        !$past(wrStb) |-> $stable(p2pDiv_q)
    ) else $error("point-to-point setting moved without a write");
    stepEdge_a: assert property (
        stepPulse_q |-> $past(ctrlStep_q) && $past(pinSync[0]) && !$past(pinSync[0], 2)
    ) else $error("step pulse without a rising edge in step mode");
    encoderCopy_a: assert property (
        ##1 encBufP_q == $past(pinSync[4:2]) && encBufN_q == ~encBufP_q
    ) else $error("encoder copy wrong or pair not complementary");
    runStable_a: assert property (
        linkEnable && $past(linkEnable) |-> $stable(nodeAddr_q) && $stable(baudDiv_q)
    ) else $error("settings moved while the link runs");
    settleTime_a: assert property (
        $rose(state_q == snsd_pkg::ST_RESOLVE) |-> $past(settleCnt_q) == 8'hC7
    ) else $error("resolve before the settle time ran out");

    linkStart_c: cover property ($rose(linkEnable));
    nvmFallback_c: cover property (linkEnable && addrFromNvm_q && rateFromNvm_q);
    stepSeen_c: cover property (stepPulse_q);
    reload_c: cover property (linkEnable && reloadReq_q ##1 !linkEnable);

endmodule : snsd_setting_decoder

`default_nettype wire

// [verilog/snsd_sync.sv]
`timescale 1ns/1ns
`default_nettype none

module snsd_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Data
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule : snsd_sync

`default_nettype wire
